// ### src/qdac_top.sv
// Quad converter front end: serial word capture, input and output banks, presets.
`timescale 1ns/100ps

// Notes on behaviour
// (RULE1) Words are sixteen bits, most significant bit first.
// (RULE2) Serial data is sampled on each rising serial clock edge while chip select is low.
// (RULE3) The shift chain moves only while chip select is low.
// (RULE4) At deselect only the last sixteen bits shifted in are used.
// (RULE5) Hosts sending two bytes keep chip select low across both.
// (RULE6) Chip select rising loads the code into the addressed input register.
// (RULE7) Preset low forces all registers to zero or half scale per scale pin.
// (RULE8) An unused preset input is tied high by the system.
// (RULE9) Power-up sets all registers to zero or half scale per scale pin.
// (RULE10) Output registers keep the reset value until a word is loaded.
// (RULE11) The load strobe updates all four output registers together.
// (RULE12) Four independent channels, each a 14-bit unsigned code.
// (RULE13) Bits 15:14 pick channel A to D, bits 13:0 the code.
// (RULE14) Load strobe low makes outputs follow inputs; high holds them.
// (RULE15) Serial output shows each bit seventeen clocks after it entered.
// (RULE16) The half-scale preset code is 2000h.
// (RULE17) An active preset overrides word loads and load strobe transfers.
// (RULE18) Shifting continues during preset; only the banks are held.
module qdac_top (
    input  wire logic                clk,           // System clock, 100 MHz.
    input  wire logic                resetn,        // Power-on reset, active low.
    input  wire logic                sclk,          // Serial link clock.
    input  wire logic                cs_n,          // Chip select, active low.
    input  wire logic                serial_in,     // Serial data input.
    input  wire logic                load_strobe_n, // Level load strobe, active low.
    input  wire logic                preset_n,      // Asynchronous preset, active low.
    input  wire logic                scale_sel,     // Preset scale: 0 zero, 1 half.
    output logic                     serial_out,    // Daisy-chain data output.
    output qdac_pkg::qdac_bank_t     code_out,      // Output register codes.
    output qdac_pkg::qdac_bank_t     input_code,    // Input register codes.
    output logic                     word_loaded    // Pulse when a word was stored.
);

    logic [15:0]                     link_word;
    logic [3:0]                      pins_raw;
    logic [3:0]                      pins_s;
    logic                            cs_s;
    logic                            load_s;
    logic                            preset_s;
    logic                            scale_s;
    logic                            cs_rise;
    logic [1:0]                      word_addr;
    qdac_pkg::qdac_code_t            word_code;
    qdac_pkg::qdac_code_t            preset_val;
    qdac_pkg::qdac_core_t            st_q;
    qdac_pkg::qdac_core_t            st_d;

    // Shifting runs independently of the presets, on the host clock.
    qdac_shift u_shift (
        .sclk       (sclk),
        .resetn     (resetn),
        .cs_n       (cs_n),
        .serial_in  (serial_in),
        .word       (link_word),
        .serial_out (serial_out)
    );  // RULE18

    assign pins_raw[qdac_pkg::PIN_CS]     = cs_n;
    assign pins_raw[qdac_pkg::PIN_LOAD]   = load_strobe_n;
    assign pins_raw[qdac_pkg::PIN_PRESET] = preset_n;
    assign pins_raw[qdac_pkg::PIN_SCALE]  = scale_sel;

    qdac_sync #(
        .W       (qdac_pkg::SYNC_W),
        .RST_VAL (qdac_pkg::PIN_RST)
    ) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      (pins_raw),
        .q      (pins_s)
    );

    assign cs_s     = pins_s[qdac_pkg::PIN_CS];
    assign load_s   = pins_s[qdac_pkg::PIN_LOAD];
    assign preset_s = pins_s[qdac_pkg::PIN_PRESET];
    assign scale_s  = pins_s[qdac_pkg::PIN_SCALE];

    // The link word is sampled only after chip select has risen and passed
    // the synchroniser. The chain ignores clock edges while deselected, so
    // the word is quiet by then; this trades a few cycles of latency for a
    // crossing without a return handshake on a clock that may stop.
    assign cs_rise    = cs_s & ~st_q.cs_prev;  // RULE6
    assign word_addr  = link_word[qdac_pkg::ADDR_HI_POS:qdac_pkg::ADDR_LO_POS];  // RULE13
    assign word_code  = link_word[qdac_pkg::CODE_MSB:0];  // RULE13
    assign preset_val = scale_s ? qdac_pkg::CODE_HALF : qdac_pkg::CODE_ZERO;  // RULE16

    always_comb begin
        st_d         = st_q;
        st_d.cs_prev = cs_s;
        st_d.loaded  = 1'b0;
        if (st_q.phase == qdac_pkg::QDAC_PH_INIT) begin
            // Hold the power-on preset until the scale pin level is settled.
            for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
                st_d.in_regs.ch[i]  = preset_val;  // RULE9
                st_d.out_regs.ch[i] = preset_val;  // RULE9
            end
            st_d.init_cnt = st_q.init_cnt + 2'h1;
            if (st_q.init_cnt == qdac_pkg::INIT_LAST) begin
                st_d.phase = qdac_pkg::QDAC_PH_RUN;
            end
        end else if (!preset_s) begin  // RULE17
            for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
                st_d.in_regs.ch[i]  = preset_val;  // RULE7
                st_d.out_regs.ch[i] = preset_val;  // RULE7
            end
        end else begin
            // Outputs move only through the strobe, so they keep the reset
            // value until a word has been loaded and the strobe is low.
            for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin  // RULE12
                if (cs_rise && (word_addr == 2'(i))) begin
                    st_d.in_regs.ch[i] = word_code;  // RULE6
                end
                if (!load_s) begin
                    st_d.out_regs.ch[i] = st_q.in_regs.ch[i];  // RULE11 RULE14 RULE10
                end
            end
            st_d.loaded = cs_rise;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '{phase:    qdac_pkg::QDAC_PH_INIT,
                      init_cnt: qdac_pkg::INIT_RST,
                      cs_prev:  1'b1,
                      loaded:   1'b0,
                      in_regs:  '0,
                      out_regs: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign code_out    = st_q.out_regs;
    assign input_code  = st_q.in_regs;
    assign word_loaded = st_q.loaded;

    default clocking cb_sys @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_running;
        st_q.phase == qdac_pkg::QDAC_PH_RUN && preset_s;
    endsequence

    sequence s_word_taken;
        s_running ##0 cs_rise;
    endsequence

    sequence s_strobe_open;
        s_running ##0 !load_s;
    endsequence

    a_preset_zero: assert property ((!preset_s && !scale_s) |=>  // RULE7
        (code_out == '0) && (input_code == '0))
        else $error("zero-scale preset not applied");

    a_preset_half: assert property ((!preset_s && scale_s) |=>  // RULE16
        (code_out == {4{qdac_pkg::CODE_HALF}}) && (input_code == {4{qdac_pkg::CODE_HALF}}))
        else $error("half-scale preset not applied");

    a_word_store: assert property (s_word_taken |=>  // RULE6
        (input_code.ch[$past(word_addr)] == $past(word_code)) && word_loaded)
        else $error("word not stored in addressed channel");

    a_input_hold: assert property ((s_running ##0 !cs_rise) |=>  // RULE6
        $stable(input_code) && !word_loaded)
        else $error("input registers changed without a word");

    a_strobe_follow: assert property (s_strobe_open |=>  // RULE14
        code_out == $past(input_code))
        else $error("outputs not following inputs under strobe");

    a_strobe_hold: assert property ((s_running ##0 load_s) |=>  // RULE11
        $stable(code_out))
        else $error("outputs moved with strobe high");

    a_init_bound: assert property ((st_q.phase == qdac_pkg::QDAC_PH_INIT) |->  // RULE9
        ##[0:4] (st_q.phase == qdac_pkg::QDAC_PH_RUN))
        else $error("power-on preset did not end in time");

    a_preset_wins: assert property ((!preset_s && cs_rise &&  // RULE17
        st_q.phase == qdac_pkg::QDAC_PH_RUN) |=> !word_loaded &&
        (input_code == {4{$past(preset_val)}}))
        else $error("word load overrode active preset");

endmodule

// ### src/qdac_pkg.sv
// Shared constants and types for the quad converter serial load front end.
package qdac_pkg;

    localparam int          WORD_W      = 16;
    localparam int          CODE_W      = 14;
    localparam int          NUM_CH      = 4;
    localparam int          ADDR_W      = 2;
    localparam int          SDO_DEPTH   = 17;
    localparam int          ADDR_HI_POS = 15;
    localparam int          ADDR_LO_POS = 14;
    localparam int          CODE_MSB    = 13;
    localparam int          SYNC_W      = 4;

    localparam logic [13:0] CODE_ZERO   = 14'h0000;
    localparam logic [13:0] CODE_HALF   = 14'h2000;

    // Positions of the pin levels inside the synchroniser bundle.
    localparam int          PIN_CS      = 0;
    localparam int          PIN_LOAD    = 1;
    localparam int          PIN_PRESET  = 2;
    localparam int          PIN_SCALE   = 3;
    localparam logic [3:0]  PIN_RST     = 4'h7;

    // Power-on preset is held one clock more than this after reset release.
    localparam logic [1:0]  INIT_LAST   = 2'h3;
    localparam logic [1:0]  INIT_RST    = 2'h0;

    typedef logic [13:0] qdac_code_t;

    typedef struct packed {
        qdac_code_t [3:0] ch;
    } qdac_bank_t;

    typedef enum logic [1:0] {
        QDAC_PH_INIT = 2'b01,
        QDAC_PH_RUN  = 2'b10
    } qdac_phase_t;

    typedef struct packed {
        qdac_phase_t phase;
        logic [1:0]  init_cnt;
        logic        cs_prev;
        logic        loaded;
        qdac_bank_t  in_regs;
        qdac_bank_t  out_regs;
    } qdac_core_t;

    typedef struct packed {
        logic [16:0] chain;
    } qdac_link_t;

endpackage

// ### src/qdac_sync.sv
// Two-stage level synchroniser for asynchronous pin inputs.
`timescale 1ns/100ps
module qdac_sync #(
    parameter int               W       = 4,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    input  wire logic           clk,     // System clock.
    input  wire logic           resetn,  // Asynchronous reset, active low.
    input  wire logic [W-1:0]   d,       // Asynchronous levels.
    output logic      [W-1:0]   q        // Synchronised levels.
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } qdac_sync_st_t;

    qdac_sync_st_t st_q;
    qdac_sync_st_t st_d;

    // The first stage feeds the second stage only.
    always_comb begin
        st_d      = st_q;
        st_d.meta = d;
        st_d.stab = st_q.meta;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '{meta: RST_VAL, stab: RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.stab;

endmodule

// ### src/qdac_shift.sv
// Serial shift chain clocked by the link clock, with the daisy-chain output.
`timescale 1ns/100ps
module qdac_shift (
    input  wire logic        sclk,       // Link clock from the host.
    input  wire logic        resetn,     // Asynchronous reset, active low.
    input  wire logic        cs_n,       // Chip select, active low.
    input  wire logic        serial_in,  // Serial data, sampled on rising sclk.
    output logic [15:0]      word,       // Last sixteen bits shifted in.
    output logic             serial_out  // Daisy-chain data output.
);

    qdac_pkg::qdac_link_t st_q;
    qdac_pkg::qdac_link_t st_d;

    // New bits enter at the bottom, so the first bit sent ends up on top.
    always_comb begin
        st_d = st_q;
        if (!cs_n) begin  // RULE3
            st_d.chain = {st_q.chain[15:0], serial_in};  // RULE1 RULE2
        end
    end

    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Surplus leading bits are not part of the word; the newest of them drives serial_out.
    assign word       = st_q.chain[15:0];  // RULE4
    assign serial_out = st_q.chain[16];    // RULE15

    a_shift_adv: assert property (@(posedge sclk) disable iff (!resetn)  // RULE2
        !cs_n |=> (st_q.chain[0] == $past(serial_in)) &&
                  (st_q.chain[16:1] == $past(st_q.chain[15:0])))
        else $error("shift chain did not advance by one bit");

    a_shift_idle: assert property (@(posedge sclk) disable iff (!resetn)  // RULE3
        cs_n |=> $stable(st_q.chain))
        else $error("shift chain moved while deselected");

    a_sdo_step: assert property (@(posedge sclk) disable iff (!resetn)  // RULE15
        (!cs_n ##1 !cs_n) |=> serial_out == $past(st_q.chain[14], 2))
        else $error("daisy-chain output not delayed along the chain");

endmodule

// ### tb/qdac_host_model.sv
// Host side of the serial link: drives clock, select and data frames.
`timescale 1ns/100ps
module qdac_host_model (
    output logic sclk,      // Link clock, stands low between pulses.
    output logic cs_n,      // Chip select, active low.
    output logic serial_in  // Serial data to the device.
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
    end

    task automatic open_frame();
        cs_n = 1'b0;
        #15;
    endtask

    // Data changes while the clock is low, so the rising edge sees it settled.
    task automatic shift_bits(input logic [23:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = w[i];
            #15 sclk = 1'b1;
            #15 sclk = 1'b0;
        end
    endtask

    // The released data line is inverted so a stale value never looks valid.
    task automatic close_frame();
        #15 cs_n = 1'b1;
        serial_in = ~serial_in;
        #60;
    endtask

    task automatic idle_clocks(input int n);
        repeat (n) begin
            #15 sclk = 1'b1;
            #15 sclk = 1'b0;
        end
    endtask
endmodule

// ### tb/quad_dac_serial_load_control_tb.sv
// Self-checking bench for the quad converter serial load front end.
`timescale 1ns/100ps
module quad_dac_serial_load_control_tb;
    logic                 clk;
    logic                 resetn;
    logic                 sclk;
    logic                 cs_n;
    logic                 serial_in;
    logic                 load_strobe_n;
    logic                 preset_n;
    logic                 scale_sel;
    logic                 serial_out;
    qdac_pkg::qdac_bank_t code_out;
    qdac_pkg::qdac_bank_t input_code;
    logic                 word_loaded;
    qdac_pkg::qdac_bank_t exp_in;
    qdac_pkg::qdac_bank_t half4;
    int                   miscompares = 0;
    int                   compares = 0;
    int                   loads = 0;
    int                   exp_ld = 0;
    int                   cycles = 0;

    qdac_host_model i_qdac_host_model (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in));

    qdac_top i_qdac_top (
        .clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
        .load_strobe_n(load_strobe_n), .preset_n(preset_n), .scale_sel(scale_sel),
        .serial_out(serial_out), .code_out(code_out), .input_code(input_code),
        .word_loaded(word_loaded)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (word_loaded === 1'b1)
            loads <= loads + 1;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp(input logic [55:0] got, input logic [55:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Writes one word; the store lands a few clocks after deselect.
    task automatic send(input logic [23:0] w, input int n, input logic store);
        i_qdac_host_model.open_frame();
        i_qdac_host_model.shift_bits(w, n);
        i_qdac_host_model.close_frame();
        repeat (10) @(posedge clk);
        if (store) begin
            exp_ld++;
            exp_in.ch[w[15:14]] = w[13:0];
        end
        cmp(56'(loads), 56'(exp_ld));
        cmp(input_code, exp_in);
    endtask

    initial begin
        half4 = {4{qdac_pkg::CODE_HALF}};
        exp_in = half4;
        resetn = 1'b0;
        load_strobe_n = 1'b1;
        preset_n = 1'b1;
        scale_sel = 1'b1;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (12) @(posedge clk);
        cmp(code_out, half4);
        cmp(input_code, half4);
        $display("test power_on done");

        send({8'h00, 2'd0, 14'h3fff}, 16, 1'b1);
        send({8'h00, 2'd1, 14'h0001}, 16, 1'b1);
        send({8'hff, 2'd2, 14'h0123}, 24, 1'b1);
        i_qdac_host_model.open_frame();
        i_qdac_host_model.shift_bits(24'h0000eb, 8);
        send({8'h00, 2'd3, 14'h2bcd}, 8, 1'b1);
        // An empty frame stores the unchanged chain contents again.
        send({8'h00, 2'd3, 14'h2bcd}, 0, 1'b1);
        cmp(code_out, half4);
        $display("test word_store done");

        @(posedge clk) load_strobe_n <= 1'b0;
        repeat (6) @(posedge clk);
        cmp(code_out, exp_in);
        send({8'h00, 2'd1, 14'h1555}, 16, 1'b1);
        repeat (3) @(posedge clk);
        cmp(code_out, exp_in);
        @(posedge clk) load_strobe_n <= 1'b1;
        repeat (4) @(posedge clk);
        send({8'h00, 2'd2, 14'h0aaa}, 16, 1'b1);
        exp_in.ch[2] = 14'h0123;
        cmp(code_out, exp_in);
        exp_in.ch[2] = 14'h0aaa;
        $display("test strobe done");

        send(24'h010000, 17, 1'b1);
        cmp(56'(serial_out), 56'h1);
        i_qdac_host_model.idle_clocks(4);
        cmp(56'(serial_out), 56'h1);
        send(24'h00ffff, 17, 1'b1);
        cmp(56'(serial_out), 56'h0);
        $display("test daisy_chain done");

        @(posedge clk) begin
            scale_sel <= 1'b0;
            preset_n <= 1'b0;
            load_strobe_n <= 1'b0;
        end
        repeat (6) @(posedge clk);
        exp_in = '0;
        cmp(code_out, exp_in);
        send(24'h014321, 17, 1'b0);
        cmp(code_out, exp_in);
        cmp(56'(serial_out), 56'h1);
        @(posedge clk) scale_sel <= 1'b1;
        repeat (6) @(posedge clk);
        cmp(code_out, half4);
        @(posedge clk) preset_n <= 1'b1;
        repeat (6) @(posedge clk);
        exp_in = half4;
        send({8'h00, 2'd0, 14'h0042}, 16, 1'b1);
        repeat (4) @(posedge clk);
        cmp(code_out, exp_in);
        $display("test preset done");
        stop_test();
    end
endmodule
